// ===== core/received_level_code_adc_readout.sv
/*
  Received-level converter control: control word and status word over
  AXI4-Lite, conversion-rate selection, source selection and the
  front-end gain bit. Assumes a single 10 MHz ref_clk, a synchronous
  active-high reset, and an analog comparator whose output arrives
  asynchronously on compOut.
*/
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - one bit selects minimum LNA gain, 6 dB down
// - status word shows the 6-bit level code
// - control bits choose which source is converted
// - supply code step is 85 mV, 1.25V reference
// - level code step about 1.3 dB, linear
// - two-bit select gives 640/320/160/80 kHz
// - fastest rate refreshes result within 100 us
// - without extended features only 80 kHz applies
module received_level_code_adc_readout
  import received_level_code_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end
  input wire logic compOut,
  output logic [5:0] dacCode,
  output logic sampling,
  output logic [1:0] inputSelect,
  output logic lnaMinGain
);

  logic [31:0] ctrl, next_ctrl;
  received_level_code_status_t status, next_status;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid, rValid, next_rValid;
  logic [1:0] bResp, next_bResp, rResp, next_rResp;
  logic [31:0] rData, next_rData;
  logic compMeta, compSync;
  logic [1:0] clkSel, srcSel;
  logic [1:0] effSel, effSrc, next_effSel, next_effSrc;
  logic [7:0] stepDiv;
  logic restart, convDone, doWrite, doRead, statusRead;
  logic [5:0] convResult;

  // ----------------------------------------------------------------------
  // comparator synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compMeta <= 1'b0;
      compSync <= 1'b0;
    end else begin
      compMeta <= compOut;
      compSync <= compMeta;
    end
  end

  // ----------------------------------------------------------------------
  // conversion rate and source
  // ----------------------------------------------------------------------
  always_comb begin
    clkSel = ctrl[ADC_CLOCK_SEL_LSB +: 2];
    srcSel = ctrl[SOURCE_SEL_LSB +: 2];
    // faster rates exist only once extended features are on
    next_effSel = ctrl[EXT_FEATURES_BIT] ? clkSel : ADC_CLK_80K;
    next_effSrc = srcSel;
    case (effSel)
      ADC_CLK_640K: stepDiv = DIV_640K;
      ADC_CLK_320K: stepDiv = DIV_320K;
      ADC_CLK_160K: stepDiv = DIV_160K;
      default: stepDiv = DIV_80K;
    endcase
    // a result must never mix two sources or two rates
    restart = (next_effSel != effSel) || (next_effSrc != effSrc);
  end

  received_level_code_sar_seq u_sar (
    .ref_clk(ref_clk),
    .reset(reset),
    .stepDiv(stepDiv),
    .restart(restart),
    .compHigh(compSync),
    .dacCode(dacCode),
    .sampling(sampling),
    .convDone(convDone),
    .convResult(convResult)
  );

  // ----------------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------------
  always_comb begin
    s_axi_awready = !awHeld && !bValid;
    s_axi_wready = !wHeld && !bValid;
    s_axi_arready = !rValid;
    next_awHeld = awHeld || (s_axi_awvalid && s_axi_awready);
    next_wHeld = wHeld || (s_axi_wvalid && s_axi_wready);
    next_awAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awAddr;
    next_wData = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wData;
    next_wStrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrb;
    doWrite = next_awHeld && next_wHeld && !bValid;
    doRead = s_axi_arvalid && s_axi_arready;
    next_ctrl = ctrl;
    next_bValid = bValid && !s_axi_bready;
    next_bResp = bResp;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = 2'h0;
      if (next_awAddr[7:2] == PRIMARY_CONTROL_WORD_OFFS[7:2]) begin
        for (int i = 0; i < 4; i++) begin
          if (next_wStrb[i]) begin
            next_ctrl[8*i +: 8] = next_wData[8*i +: 8];
          end
        end
        next_ctrl = next_ctrl & CTRL_WRITABLE_MASK;
      end else if (next_awAddr[7:2] != LEVEL_STATUS_OFFS[7:2]) begin
        next_bResp = 2'h2;  // unmapped: slave error
      end
    end
    next_rValid = rValid && !s_axi_rready;
    next_rData = rData;
    next_rResp = rResp;
    statusRead = 1'b0;
    if (doRead) begin
      next_rValid = 1'b1;
      next_rResp = 2'h0;
      if (s_axi_araddr[7:2] == PRIMARY_CONTROL_WORD_OFFS[7:2]) begin
        next_rData = ctrl;
      end else if (s_axi_araddr[7:2] == LEVEL_STATUS_OFFS[7:2]) begin
        next_rData = status;
        statusRead = 1'b1;
      end else begin
        next_rData = 32'h0000_0000;
        next_rResp = 2'h2;
      end
    end
    // status code and source change only when a conversion completes; a status read clears fresh
    next_status = status;
    if (statusRead) begin
      next_status.fresh = 1'b0;
    end
    if (convDone) begin
      next_status.code = convResult;
      next_status.source = effSrc;
      next_status.fresh = 1'b1;  // set wins over the read clear
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= PRIMARY_CONTROL_WORD_RESET;
      status <= '0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= 2'h0;
      rValid <= 1'b0;
      rResp <= 2'h0;
      rData <= 32'h0000_0000;
      effSel <= ADC_CLK_80K;
      effSrc <= SRC_LEVEL;
    end else begin
      ctrl <= next_ctrl;
      status <= next_status;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rResp <= next_rResp;
      rData <= next_rData;
      effSel <= next_effSel;
      effSrc <= next_effSrc;
    end
  end

  // gain bit comes straight from the control word register; inputSelect from its registered copy effSrc
  assign lnaMinGain = ctrl[LNA_MIN_GAIN_BIT];
  assign inputSelect = effSrc;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_rvalid = rValid;
  assign s_axi_rresp = rResp;
  assign s_axi_rdata = rData;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  logic [10:0] sinceResult;
  always_ff @(posedge ref_clk) begin
    if (reset || convDone || restart || effSel != ADC_CLK_640K) begin
      sinceResult <= 11'h000;
    end else if (sinceResult != 11'h7FF) begin
      sinceResult <= sinceResult + 11'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  lna_gain_a: assert property (
    doWrite && next_awAddr[7:2] == PRIMARY_CONTROL_WORD_OFFS[7:2]
    && next_wStrb[3] |=> lnaMinGain == $past(next_wData[LNA_MIN_GAIN_BIT]))
    else $error("gain bit not written");
  status_code_a: assert property (
    convDone |=> status.code == $past(convResult) && status.fresh)
    else $error("result not posted");
  source_track_a: assert property (
    $changed(ctrl[SOURCE_SEL_LSB +: 2]) |=> inputSelect == $past(srcSel)
    ##1 !convDone) else $error("source change not applied");
  rate_fast_a: assert property (
    ctrl[EXT_FEATURES_BIT] && clkSel == ADC_CLK_640K |=> stepDiv == DIV_640K)
    else $error("fast rate not selected");
  refresh_bound_a: assert property (
    sinceResult < 11'(FRESH_RESULT_CYCLES)) else $error("result too old");
  legacy_rate_a: assert property (
    !ctrl[EXT_FEATURES_BIT] |=> stepDiv == DIV_80K)
    else $error("fast rate without extended features");
  result_stable_a: assert property (
    !convDone |=> $stable(status.code) && $stable(status.source))
    else $error("status changed mid conversion");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  fast_done_c: cover property (effSel == ADC_CLK_640K && convDone);
  ctrl_write_c: cover property (doWrite && s_axi_bresp == 2'h0);
  status_read_c: cover property (statusRead ##1 s_axi_rvalid);

endmodule // received_level_code_adc_readout

`default_nettype wire

// ===== core/received_level_code_pkg.sv
/*
  Package for the received-level converter control block: register
  offsets, bit positions, converter timing and the status layout.
  Assumes a 10 MHz reference clock and a 32-bit AXI4-Lite register bus.
*/
package received_level_code_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIMARY_CONTROL_WORD_OFFS = 8'h00;
  localparam logic [7:0] LEVEL_STATUS_OFFS = 8'h04;
  localparam logic [31:0] PRIMARY_CONTROL_WORD_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------------
  localparam int EXT_FEATURES_BIT = 0;
  localparam int SOURCE_SEL_LSB = 1;  // two bits
  localparam int ADC_CLOCK_SEL_LSB = 3;  // two bits
  localparam int LNA_MIN_GAIN_BIT = 25;
  localparam logic [31:0] CTRL_WRITABLE_MASK = 32'h0200_001F;

  // converter input sources
  localparam logic [1:0] SRC_LEVEL = 2'h0;
  localparam logic [1:0] SRC_SUPPLY = 2'h1;
  localparam logic [1:0] SRC_DISC_OFFSET = 2'h2;

  // level_adc_clock_select codes
  localparam logic [1:0] ADC_CLK_640K = 2'h3;
  localparam logic [1:0] ADC_CLK_320K = 2'h2;
  localparam logic [1:0] ADC_CLK_160K = 2'h1;
  localparam logic [1:0] ADC_CLK_80K = 2'h0;

  // ----------------------------------------------------------------------
  // timing: reference clock and converter step rates
  // ----------------------------------------------------------------------
  localparam int REF_CLK_KHZ = 10000;
  localparam int ADC_640K_KHZ = 640;
  localparam int ADC_320K_KHZ = 320;
  localparam int ADC_160K_KHZ = 160;
  localparam int ADC_80K_KHZ = 80;
  // step periods round down, so each step rate is at least the nominal one
  localparam logic [7:0] DIV_640K = 8'(REF_CLK_KHZ / ADC_640K_KHZ);
  localparam logic [7:0] DIV_320K = 8'(REF_CLK_KHZ / ADC_320K_KHZ);
  localparam logic [7:0] DIV_160K = 8'(REF_CLK_KHZ / ADC_160K_KHZ);
  localparam logic [7:0] DIV_80K = 8'(REF_CLK_KHZ / ADC_80K_KHZ);
  // a conversion is settle steps + 6 bit steps, 63 steps below 64
  localparam logic [6:0] SETTLE_STEPS = 7'h39;
  localparam int CODE_BITS = 6;
  localparam int FRESH_RESULT_US = 100;
  localparam int FRESH_RESULT_CYCLES = FRESH_RESULT_US * REF_CLK_KHZ / 1000;

  // ----------------------------------------------------------------------
  // scale of one code step, for software
  // ----------------------------------------------------------------------
  localparam int SUPPLY_LSB_MV = 85;
  localparam int SUPPLY_VREF_MV = 1250;
  localparam int LEVEL_LSB_CENTI_DB = 130;
  localparam int LNA_MIN_GAIN_ATTEN_DB = 6;

  // status word layout
  typedef struct packed {
    logic [22:0] zero;
    logic fresh;
    logic [1:0] source;
    logic [5:0] code;
  } received_level_code_status_t;

endpackage

// ===== core/received_level_code_sar_seq.sv
/*
  Successive-approximation sequencer: paces steps from the reference
  clock, settles, then resolves six bits against an external comparator.
  Assumes the comparator input is already synchronised to ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module received_level_code_sar_seq
  import received_level_code_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic [7:0] stepDiv,
  input wire logic restart,
  input wire logic compHigh,
  // converter side
  output logic [5:0] dacCode,
  output logic sampling,
  // result
  output logic convDone,
  output logic [5:0] convResult
);

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_DONE = 3'b100
  } received_level_code_sar_state_t;

  received_level_code_sar_state_t state, next_state;
  logic [7:0] divCnt, next_divCnt;
  logic [6:0] stepCnt, next_stepCnt;
  logic [2:0] bitIdx, next_bitIdx;
  logic [5:0] trial, next_trial;
  logic [5:0] result, next_result;
  logic [5:0] mask;
  logic step;

  // ----------------------------------------------------------------------
  // step pacing and bit decisions
  // ----------------------------------------------------------------------
  always_comb begin
    step = (divCnt == stepDiv - 8'h01);
    mask = 6'h01 << bitIdx;
    next_divCnt = (step || restart) ? 8'h00 : divCnt + 8'h01;
    next_state = state;
    next_stepCnt = stepCnt;
    next_bitIdx = bitIdx;
    next_trial = trial;
    next_result = result;
    case (state)
      ST_SETTLE: begin
        next_trial = 6'h00;
        if (step) begin
          next_stepCnt = stepCnt + 7'h01;
          if (stepCnt == SETTLE_STEPS - 7'h01) begin
            next_state = ST_CONVERT;
            next_bitIdx = 3'(CODE_BITS - 1);
            next_trial = 6'h20;
          end
        end
      end
      ST_CONVERT: begin
        if (step) begin
          // keep the trial bit only if the input is at or above it
          next_trial = (trial & ~mask) | (compHigh ? mask : 6'h00)
                       | (mask >> 1);
          if (bitIdx == 3'h0) begin
            // latch the finished code now, so done carries this result
            next_result = next_trial;
            next_state = ST_DONE;
          end else begin
            next_bitIdx = bitIdx - 3'h1;
          end
        end
      end
      ST_DONE: begin
        // result held here until the next conversion completes
        next_result = trial;
        next_state = ST_SETTLE;
        next_stepCnt = 7'h00;
      end
      default: begin
        next_state = ST_SETTLE;
        next_stepCnt = 7'h00;
      end
    endcase
    // a source or rate change throws away the conversion under way
    if (restart) begin
      next_state = ST_SETTLE;
      next_stepCnt = 7'h00;
      next_trial = 6'h00;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_SETTLE;
      divCnt <= 8'h00;
      stepCnt <= 7'h00;
      bitIdx <= 3'h0;
      trial <= 6'h00;
      result <= 6'h00;
    end else begin
      state <= next_state;
      divCnt <= next_divCnt;
      stepCnt <= next_stepCnt;
      bitIdx <= next_bitIdx;
      trial <= next_trial;
      result <= next_result;
    end
  end

  assign dacCode = trial;
  assign sampling = (state == ST_SETTLE);
  assign convDone = (state == ST_DONE);
  assign convResult = result;

endmodule // received_level_code_sar_seq

`default_nettype wire

// ===== test/received_level_code_front_model.sv
/*
  Analog front-end model: picks the converted source and compares it
  with the trial code. Assumes an ideal comparator that answers at once.
*/
`timescale 1ns/1ns
`default_nettype none

module received_level_code_front_model
  import received_level_code_pkg::*;
#(
  parameter int SUPPLY_MV = 2975,
  parameter logic [5:0] DISC_CODE = 6'h2A
)
(
  // converter side of the block
  input wire logic [5:0] dacCode,
  input wire logic [1:0] inputSelect,
  // level input, set by the bench
  input wire logic [5:0] levelCode,
  // comparator
  output logic compOut
);
  logic [5:0] selected;

  // unused select code falls back to level, like a plain mux
  always_comb begin
    case (inputSelect)
      SRC_SUPPLY: selected = 6'(SUPPLY_MV / SUPPLY_LSB_MV);
      SRC_DISC_OFFSET: selected = DISC_CODE;
      default: selected = levelCode;
    endcase
    compOut = (selected >= dacCode);
  end
endmodule // received_level_code_front_model

`default_nettype wire

// ===== test/test_received_level_code_adc_readout.sv
/*
  Bench: rows of control words, then bus edge cases, result hold and
  a mid-run reset. Assumes the front-end model in received_level_code_front_model.
*/
`timescale 1ns/1ns
`default_nettype none

module test_received_level_code_adc_readout
  import received_level_code_pkg::*;
;
  localparam int SUP_MV = 2975;
  localparam logic [5:0] DISC = 6'h2A;
  localparam int LIMIT = 60000;
  typedef struct {
    logic [31:0] ctrl;
    int div;
    logic [1:0] src;
  } received_level_code_row_t;

  logic ref_clk, reset, compOut, sampling, lnaMinGain;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, inputSelect, rsp;
  logic [5:0] dacCode, levelCode;
  received_level_code_status_t st;
  received_level_code_row_t rows [5];
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int t0;

  received_level_code_adc_readout dut (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compOut, .dacCode,
    .sampling, .inputSelect, .lnaMinGain);
  received_level_code_front_model #(.SUPPLY_MV(SUP_MV), .DISC_CODE(DISC)) front (
    .dacCode, .inputSelect, .levelCode, .compOut);

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // a hang counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // each channel held until its own ready; bready up until bvalid
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    st = received_level_code_status_t'(rd);
  endtask

  // polling clears fresh, so a set flag always means a new result
  task automatic wait_fresh();
    do axi_read(LEVEL_STATUS_OFFS);
    while (st.fresh !== 1'b1);
  endtask

  function automatic logic [5:0] exp_code(input logic [1:0] s);
    if (s == SRC_SUPPLY) return 6'(SUP_MV / SUPPLY_LSB_MV);
    if (s == SRC_DISC_OFFSET) return DISC;
    return levelCode;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    levelCode = 6'h17;
    // last row runs without extended features: rate stays slowest
    rows = '{'{32'hFE00_0019, DIV_640K, SRC_LEVEL},
             '{32'h0000_0013, DIV_320K, SRC_SUPPLY},
             '{32'h0000_000D, DIV_160K, SRC_DISC_OFFSET},
             '{32'h0000_0001, DIV_80K, SRC_LEVEL},
             '{32'h0000_001A, DIV_80K, SRC_SUPPLY}};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    axi_read(PRIMARY_CONTROL_WORD_OFFS);
    chk(rd, PRIMARY_CONTROL_WORD_RESET);
    chk(lnaMinGain, 1'b0);
    chk(inputSelect, SRC_LEVEL);
    $display("reset values done");
    foreach (rows[i]) begin
      axi_write(PRIMARY_CONTROL_WORD_OFFS, rows[i].ctrl, 4'hF);
      chk(rsp, 2'h0);
      @(posedge ref_clk);
      t0 = cycles;
      chk(inputSelect, rows[i].src);
      chk(lnaMinGain, rows[i].ctrl[LNA_MIN_GAIN_BIT]);
      // the restart puts the converter back into settling, trial zero
      chk({sampling, dacCode}, 7'h40);
      axi_read(PRIMARY_CONTROL_WORD_OFFS);
      chk(rd, rows[i].ctrl & CTRL_WRITABLE_MASK);
      axi_read(LEVEL_STATUS_OFFS);
      wait_fresh();
      chk((cycles - t0) >= 62 * rows[i].div
          && (cycles - t0) <= 64 * rows[i].div + 16, 1'b1);
      chk(st.code, exp_code(rows[i].src));
      chk(st.source, rows[i].src);
      $display("row %0d done", i);
    end
    // unmapped places, read-only status, one byte lane
    axi_read(8'h08);
    chk(rsp, 2'h2);
    chk(rd, 32'h0000_0000);
    axi_write(8'h0C, 32'hFFFF_FFFF, 4'hF);
    chk(rsp, 2'h2);
    axi_write(LEVEL_STATUS_OFFS, 32'hFFFF_FFFF, 4'hF);
    chk(rsp, 2'h0);
    axi_write(PRIMARY_CONTROL_WORD_OFFS, 32'hFFFF_FFFF, 4'h8);
    chk(rsp, 2'h0);
    axi_read(PRIMARY_CONTROL_WORD_OFFS);
    chk(rd, 32'h0200_001A);
    $display("bus edge cases done");
    // level moves just after a result: old code must stand
    axi_write(PRIMARY_CONTROL_WORD_OFFS, 32'h0200_0000, 4'hF);
    axi_read(LEVEL_STATUS_OFFS);
    wait_fresh();
    chk(st.code, 6'h17);
    levelCode <= 6'h30;
    axi_read(LEVEL_STATUS_OFFS);
    chk(st.code, 6'h17);
    wait_fresh();
    chk(st.code, 6'h30);
    $display("result hold done");
    reset <= 1'b1;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    axi_read(PRIMARY_CONTROL_WORD_OFFS);
    chk(rd, PRIMARY_CONTROL_WORD_RESET);
    chk(lnaMinGain, 1'b0);
    // no conversion can finish this soon, so status is still cleared
    axi_read(LEVEL_STATUS_OFFS);
    chk(rd, 32'h0000_0000);
    $display("mid-run reset done");
    finish_test();
  end
endmodule // test_received_level_code_adc_readout

`default_nettype wire
